// ==== shared/phy_led_pkg.sv ====
// Package: constants and types for the PHY mode and indicator block
package phy_led_pkg;
    // Operation select codes
    localparam logic [2:0] OPSEL_AN_ALL = 3'h0;
    localparam logic [2:0] OPSEL_AN_100 = 3'h1;
    localparam logic [2:0] OPSEL_AN_10 = 3'h2;
    localparam logic [2:0] OPSEL_RSVD = 3'h3;
    localparam logic [2:0] OPSEL_F100_FDX = 3'h4;
    localparam logic [2:0] OPSEL_F100_HDX = 3'h5;
    localparam logic [2:0] OPSEL_F10_FDX = 3'h6;
    localparam logic [2:0] OPSEL_F10_HDX = 3'h7;
    localparam logic [3:0] TEST_NORMAL = 4'h0;
    // Ability bit positions: 10H, 10F, 100H, 100F
    localparam int ABIL_10H = 0;
    localparam int ABIL_10F = 1;
    localparam int ABIL_100H = 2;
    localparam int ABIL_100F = 3;
    localparam logic [3:0] ABIL_ALL = 4'hf;
    localparam logic [3:0] ABIL_100 = 4'hc;
    localparam logic [3:0] ABIL_10 = 4'h3;
    localparam logic [3:0] ABIL_NONE = 4'h0;
    // Clock and timing
    localparam int CLK_MHZ = 100;
    localparam int FLASH_HALF_MS = 50;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;
    localparam int RESET_MIN_NS = 2000;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;

    // Link configuration derived from the strap
    typedef struct packed {
        logic autoneg;
        logic [3:0] abil;
        logic speed100;
        logic full_dpx;
    } link_cfg_t;

    // Raw status from the PHY core
    typedef struct packed {
        logic link_up;
        logic speed100;
        logic full_dpx;
        logic coll;
        logic rx_act;
        logic tx_act;
    } phy_stat_t;
endpackage

// ==== hw/phy_mode_led_status.sv ====
// Strap decode and indicator driver for the embedded Ethernet PHY
//
// Contract
// - Strap 000: negotiate, advertising all speed and duplex abilities.
// - Strap 001 advertises only 100 FDX/HDX; 010 only 10 FDX/HDX.
// - Strap 100 forces 100 full duplex; 101 forces 100 half duplex.
// - Strap 110 forces 10 full; 111 forces 10 half; no negotiation.
// - Link indicator low while a good link exists.
// - Link indicator steady when idle, flashes during traffic.
// - Speed indicator low at 100 Mbit, high otherwise.
// - Duplex indicator low in full duplex, high in half.
// - Collision indicator low while collision is detected.
// - Receive indicator low while receiving frames.
// - Transmit indicator low while transmitting frames.
`timescale 1ns/1ps
module phy_mode_led_status
    import phy_led_pkg::*;
#(
    parameter int FLASH_HALF = FLASH_HALF_CYC
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [2:0] PHY_OPERATION_SELECT,
    input wire logic [3:0] FACTORY_TEST_SELECT,
    input wire logic PHY_LINK_UP,
    input wire logic PHY_SPEED100,
    input wire logic PHY_FULL_DPX,
    input wire logic PHY_COLL,
    input wire logic PHY_RX_ACT,
    input wire logic PHY_TX_ACT,
    output logic CFG_AUTONEG,
    output logic [3:0] CFG_ABILITY,
    output logic CFG_SPEED100,
    output logic CFG_FULL_DPX,
    output logic TEST_MODE_ACTIVE,
    output logic LINK_INDICATOR_N,
    output logic SPEED_INDICATOR_N,
    output logic DUPLEX_INDICATOR_N,
    output logic COLLISION_INDICATOR_N,
    output logic RX_ACTIVITY_INDICATOR_N,
    output logic TX_ACTIVITY_INDICATOR_N
);

    // Strap decode; reserved code falls back to full negotiation
    function automatic link_cfg_t decode_opsel(input logic [2:0] sel);
        link_cfg_t c;
        c = '{autoneg: 1'b1, abil: ABIL_ALL, speed100: 1'b1,
              full_dpx: 1'b1};
        case (sel)
            OPSEL_AN_ALL: c.abil = ABIL_ALL;
            OPSEL_AN_100: c.abil = ABIL_100;
            OPSEL_AN_10: c.abil = ABIL_10;
            OPSEL_F100_FDX: c = '{1'b0, ABIL_NONE, 1'b1, 1'b1};
            OPSEL_F100_HDX: c = '{1'b0, ABIL_NONE, 1'b1, 1'b0};
            OPSEL_F10_FDX: c = '{1'b0, ABIL_NONE, 1'b0, 1'b1};
            OPSEL_F10_HDX: c = '{1'b0, ABIL_NONE, 1'b0, 1'b0};
            default: c.abil = ABIL_ALL;
        endcase
        return c;
    endfunction

    // Two-stage synchronisers for straps and PHY status
    logic [2:0] opsel_s1_ff, opsel_s2_ff;
    logic [3:0] test_s1_ff, test_s2_ff;
    phy_stat_t stat_s1_ff, stat_s2_ff;
    logic [2:0] nxt_opsel_s1, nxt_opsel_s2;
    logic [3:0] nxt_test_s1, nxt_test_s2;
    phy_stat_t nxt_stat_s1, nxt_stat_s2, stat_in;

    always_comb begin
        stat_in = '{PHY_LINK_UP, PHY_SPEED100, PHY_FULL_DPX, PHY_COLL,
                    PHY_RX_ACT, PHY_TX_ACT};
        nxt_opsel_s1 = PHY_OPERATION_SELECT;
        nxt_opsel_s2 = opsel_s1_ff;
        nxt_test_s1 = FACTORY_TEST_SELECT;
        nxt_test_s2 = test_s1_ff;
        nxt_stat_s1 = stat_in;
        nxt_stat_s2 = stat_s1_ff;
        if (RST) begin
            nxt_opsel_s1 = OPSEL_AN_ALL;
            nxt_opsel_s2 = OPSEL_AN_ALL;
            nxt_test_s1 = TEST_NORMAL;
            nxt_test_s2 = TEST_NORMAL;
            nxt_stat_s1 = '0;
            nxt_stat_s2 = '0;
        end
    end

    always_ff @(posedge CLK) begin
        opsel_s1_ff <= nxt_opsel_s1;
        opsel_s2_ff <= nxt_opsel_s2;
        test_s1_ff <= nxt_test_s1;
        test_s2_ff <= nxt_test_s2;
        stat_s1_ff <= nxt_stat_s1;
        stat_s2_ff <= nxt_stat_s2;
    end

    // Flash timer: free-running while traffic flows on a live link
    localparam int CW = $clog2(FLASH_HALF + 1);
    logic [CW-1:0] flash_cnt_ff, nxt_flash_cnt;
    logic flash_ph_ff, nxt_flash_ph;
    logic busy;

    always_comb begin
        busy = stat_s2_ff.rx_act | stat_s2_ff.tx_act;
        nxt_flash_cnt = flash_cnt_ff;
        nxt_flash_ph = flash_ph_ff;
        if (RST || !stat_s2_ff.link_up || !busy) begin
            // Idle restarts the blink in the lit phase
            nxt_flash_cnt = '0;
            nxt_flash_ph = 1'b0;
        end else if (flash_cnt_ff == CW'(FLASH_HALF - 1)) begin
            nxt_flash_cnt = '0;
            nxt_flash_ph = ~flash_ph_ff;
        end else begin
            nxt_flash_cnt = flash_cnt_ff + CW'(1);
        end
    end

    always_ff @(posedge CLK) begin
        flash_cnt_ff <= nxt_flash_cnt;
        flash_ph_ff <= nxt_flash_ph;
    end

    // Output registers; all indicators dark (high) in reset
    link_cfg_t cfg_ff, nxt_cfg;
    logic test_ff, nxt_test;
    logic [5:0] ind_n_ff, nxt_ind_n;

    always_comb begin
        nxt_cfg = decode_opsel(opsel_s2_ff);
        nxt_test = (test_s2_ff != TEST_NORMAL);
        // Dark phase only counts while traffic flows, so idle lights at once
        nxt_ind_n[5] = ~(stat_s2_ff.link_up & ~(flash_ph_ff & busy));
        // Speed and duplex only mean anything with a link up
        nxt_ind_n[4] = ~(stat_s2_ff.link_up & stat_s2_ff.speed100);
        nxt_ind_n[3] = ~(stat_s2_ff.link_up & stat_s2_ff.full_dpx);
        nxt_ind_n[2] = ~stat_s2_ff.coll;
        nxt_ind_n[1] = ~stat_s2_ff.rx_act;
        nxt_ind_n[0] = ~stat_s2_ff.tx_act;
        if (RST) begin
            nxt_cfg = decode_opsel(OPSEL_AN_ALL);
            nxt_test = 1'b0;
            nxt_ind_n = 6'h3f;
        end
    end

    always_ff @(posedge CLK) begin
        cfg_ff <= nxt_cfg;
        test_ff <= nxt_test;
        ind_n_ff <= nxt_ind_n;
    end

    always_comb begin
        CFG_AUTONEG = cfg_ff.autoneg;
        CFG_ABILITY = cfg_ff.abil;
        CFG_SPEED100 = cfg_ff.speed100;
        CFG_FULL_DPX = cfg_ff.full_dpx;
        TEST_MODE_ACTIVE = test_ff;
        LINK_INDICATOR_N = ind_n_ff[5];
        SPEED_INDICATOR_N = ind_n_ff[4];
        DUPLEX_INDICATOR_N = ind_n_ff[3];
        COLLISION_INDICATOR_N = ind_n_ff[2];
        RX_ACTIVITY_INDICATOR_N = ind_n_ff[1];
        TX_ACTIVITY_INDICATOR_N = ind_n_ff[0];
    end

    // Checks
    // One sample then three cycles, or three held samples, cover the two-flop input path plus output
    sequence s_sync3(logic a);
        a ##3 1'b1;
    endsequence

    sequence s_held3(logic a);
        a[*3];
    endsequence

    // Lit-run counter: a lamp held lit under traffic means the blink died
    localparam logic [CW:0] LIT_MAX = (CW+1)'(FLASH_HALF + 2);
    logic [CW:0] lit_run_ff, nxt_lit_run;

    always_comb begin
        nxt_lit_run = '0;
        if (!RST && !ind_n_ff[5] && stat_s2_ff.link_up && busy) begin
            nxt_lit_run = lit_run_ff + (CW+1)'(1);
        end
    end

    always_ff @(posedge CLK) begin
        lit_run_ff <= nxt_lit_run;
    end

    property p_an_all;
        @(posedge CLK) disable iff (RST)
        (opsel_s2_ff == OPSEL_AN_ALL)
            |=> (CFG_AUTONEG && CFG_ABILITY == ABIL_ALL);
    endproperty
    a_an_all: assert property (p_an_all)
        else $error("all-ability mode wrong");

    property p_an_lim;
        @(posedge CLK) disable iff (RST)
        (opsel_s2_ff == OPSEL_AN_100)
            |=> (CFG_AUTONEG && CFG_ABILITY == ABIL_100);
    endproperty
    a_an_lim: assert property (p_an_lim)
        else $error("100 ability wrong");

    property p_an_10;
        @(posedge CLK) disable iff (RST)
        (opsel_s2_ff == OPSEL_AN_10)
            |=> (CFG_AUTONEG && CFG_ABILITY == ABIL_10);
    endproperty
    a_an_10: assert property (p_an_10)
        else $error("10 ability wrong");

    property p_f100;
        @(posedge CLK) disable iff (RST)
        (opsel_s2_ff[2:1] == 2'h2) |=> (!CFG_AUTONEG && CFG_SPEED100
            && CFG_FULL_DPX == !$past(opsel_s2_ff[0]));
    endproperty
    a_f100: assert property (p_f100)
        else $error("forced 100 wrong");

    property p_f10;
        @(posedge CLK) disable iff (RST)
        (opsel_s2_ff[2:1] == 2'h3) |=> (!CFG_AUTONEG && !CFG_SPEED100
            && CFG_ABILITY == ABIL_NONE
            && CFG_FULL_DPX == !$past(opsel_s2_ff[0]));
    endproperty
    a_f10: assert property (p_f10)
        else $error("forced 10 wrong");

    property p_test;
        @(posedge CLK) disable iff (RST)
        s_held3(FACTORY_TEST_SELECT != TEST_NORMAL)
            |=> TEST_MODE_ACTIVE;
    endproperty
    a_test: assert property (p_test)
        else $error("test flag missing");

    property p_link_down;
        @(posedge CLK) disable iff (RST)
        (!PHY_LINK_UP)[*3] |=> LINK_INDICATOR_N;
    endproperty
    a_link_down: assert property (p_link_down)
        else $error("link lit without link");

    property p_link_idle;
        @(posedge CLK) disable iff (RST)
        (PHY_LINK_UP && !PHY_RX_ACT && !PHY_TX_ACT)[*4]
            |=> !LINK_INDICATOR_N;
    endproperty
    a_link_idle: assert property (p_link_idle)
        else $error("idle link dark");

    property p_flash;
        @(posedge CLK) disable iff (RST)
        lit_run_ff <= LIT_MAX;
    endproperty
    a_flash: assert property (p_flash)
        else $error("link lamp never blinks");

    property p_speed;
        @(posedge CLK) disable iff (RST)
        (PHY_LINK_UP && PHY_SPEED100)[*3] |=> !SPEED_INDICATOR_N;
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed led wrong");

    property p_dpx;
        @(posedge CLK) disable iff (RST)
        (PHY_LINK_UP && !PHY_FULL_DPX)[*3] |=> DUPLEX_INDICATOR_N;
    endproperty
    a_dpx: assert property (p_dpx)
        else $error("duplex led wrong");

    property p_coll;
        @(posedge CLK) disable iff (RST)
        s_sync3(PHY_COLL) |-> !COLLISION_INDICATOR_N;
    endproperty
    a_coll: assert property (p_coll)
        else $error("collision led late");

    property p_coll_off;
        @(posedge CLK) disable iff (RST)
        s_held3(!PHY_COLL) |=> COLLISION_INDICATOR_N;
    endproperty
    a_coll_off: assert property (p_coll_off)
        else $error("collision led stuck");

    property p_rx;
        @(posedge CLK) disable iff (RST)
        $rose(PHY_RX_ACT) ##1 PHY_RX_ACT[*2] |=> !RX_ACTIVITY_INDICATOR_N;
    endproperty
    a_rx: assert property (p_rx)
        else $error("rx led late");

    property p_rx_off;
        @(posedge CLK) disable iff (RST)
        s_held3(!PHY_RX_ACT) |=> RX_ACTIVITY_INDICATOR_N;
    endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("rx led stuck");

    property p_tx;
        @(posedge CLK) disable iff (RST)
        (!PHY_TX_ACT)[*3] |=> TX_ACTIVITY_INDICATOR_N;
    endproperty
    a_tx: assert property (p_tx)
        else $error("tx led stuck");

    property p_tx_on;
        @(posedge CLK) disable iff (RST)
        s_held3(PHY_TX_ACT) |=> !TX_ACTIVITY_INDICATOR_N;
    endproperty
    a_tx_on: assert property (p_tx_on)
        else $error("tx led late");

    property p_rst;
        @(posedge CLK) RST |=> (LINK_INDICATOR_N && COLLISION_INDICATOR_N
            && !TEST_MODE_ACTIVE);
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset defaults wrong");
endmodule

// ==== sim/media_model.sv ====
// Behavioural media side: line status levels seen by the PHY core
`timescale 1ns/1ps
module media_model
    import phy_led_pkg::*;
(
    output phy_stat_t stat
);
    // Unlinked, silent medium at power up
    initial begin
        stat = '0;
    end

    // Speed and duplex keep whatever the caller gives, even with no link,
    // so the block cannot rely on them reading zero while the link is down
    task automatic set_link(input logic up, input logic s100, input logic fdx);
        stat.link_up = up;
        stat.speed100 = s100;
        stat.full_dpx = fdx;
    endtask

    // Traffic levels: collision, receive, transmit
    task automatic set_traffic(input logic [2:0] crt);
        stat.coll = crt[2];
        stat.rx_act = crt[1];
        stat.tx_act = crt[0];
    endtask
endmodule

// ==== sim/tb_phy_mode_led_status.sv ====
// Self-checking bench for the PHY mode decode and indicator block
`timescale 1ns/1ps
module tb_phy_mode_led_status
    import phy_led_pkg::*;
;
    // Short flash half period keeps the run brief
    localparam int FH = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] opsel = OPSEL_AN_ALL;
    logic [3:0] tsel = TEST_NORMAL;
    phy_stat_t stat;
    link_cfg_t cfg;
    logic test_act;
    logic [5:0] ind_n; // Link, speed, duplex, collision, rx, tx
    int miscompares = 0;
    int tests_run = 0;

    initial begin
        forever #5 clk = ~clk;
    end

    media_model media (.stat(stat));

    phy_mode_led_status #(.FLASH_HALF(FH)) DUT (
        .CLK(clk), .RST(rst), .PHY_OPERATION_SELECT(opsel),
        .FACTORY_TEST_SELECT(tsel), .PHY_LINK_UP(stat.link_up),
        .PHY_SPEED100(stat.speed100), .PHY_FULL_DPX(stat.full_dpx),
        .PHY_COLL(stat.coll), .PHY_RX_ACT(stat.rx_act),
        .PHY_TX_ACT(stat.tx_act), .CFG_AUTONEG(cfg.autoneg),
        .CFG_ABILITY(cfg.abil), .CFG_SPEED100(cfg.speed100),
        .CFG_FULL_DPX(cfg.full_dpx), .TEST_MODE_ACTIVE(test_act),
        .LINK_INDICATOR_N(ind_n[5]), .SPEED_INDICATOR_N(ind_n[4]),
        .DUPLEX_INDICATOR_N(ind_n[3]), .COLLISION_INDICATOR_N(ind_n[2]),
        .RX_ACTIVITY_INDICATOR_N(ind_n[1]),
        .TX_ACTIVITY_INDICATOR_N(ind_n[0])
    );

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Inputs move 1 ns after an edge; outputs are read at the same offset
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic results();
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Defaults while reset is held
    task automatic check_defaults();
        check("indicators", {2'h0, ind_n}, 8'h3f);
        check("config", {1'b0, cfg}, 8'h7f);
        check("test flag", {7'h0, test_act}, 8'h00);
    endtask

    // Strap codes changed on consecutive cycles; reserved code never shown
    task automatic test_straps();
        logic [2:0] code [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
        logic [6:0] exp [7] = '{7'h7f, 7'h73, 7'h4f, 7'h03, 7'h02, 7'h01, 7'h00};
        for (int i = 0; i < 9; i++) begin
            if (i < 7) begin
                opsel = code[i];
            end
            step(1);
            if (i >= 2) begin
                check("strap config", {1'b0, cfg}, {1'b0, exp[i-2]});
            end
        end
    endtask

    task automatic test_flag();
        tsel = 4'h5;
        step(3);
        check("test flag set", {7'h0, test_act}, 8'h01);
        tsel = TEST_NORMAL;
        step(3);
        check("test flag clear", {7'h0, test_act}, 8'h00);
    endtask

    // Link, speed and duplex lamps, then each traffic lamp alone
    task automatic test_status();
        media.set_link(1'b1, 1'b1, 1'b1);
        step(3);
        check("link 100 full", {5'h0, ind_n[5:3]}, 8'h00);
        media.set_link(1'b1, 1'b0, 1'b0);
        step(3);
        check("link 10 half", {5'h0, ind_n[5:3]}, 8'h03);
        media.set_link(1'b0, 1'b1, 1'b1);
        for (int j = 0; j < 3; j++) begin
            media.set_traffic(3'h4 >> j);
            step(3);
            check("traffic lamps", {2'h0, ind_n}, {2'h0, 3'h7, ~(3'h4 >> j)});
        end
        media.set_traffic(3'h0);
    endtask

    // Low count over 16 reads: half while flashing, all when idle
    task automatic test_flash();
        logic [2:0] pat [3] = '{3'h2, 3'h1, 3'h0};
        int lows;
        media.set_link(1'b1, 1'b1, 1'b0);
        for (int k = 0; k < 3; k++) begin
            media.set_traffic(pat[k]);
            step(3);
            lows = 0;
            for (int n = 0; n < 16; n++) begin
                lows += (ind_n[5] === 1'b0) ? 1 : 0;
                step(1);
            end
            check("link lamp lows", 8'(lows), (k == 2) ? 8'h10 : 8'h08);
        end
    endtask

    // Reset in mid-run with everything active
    task automatic test_mid_reset();
        opsel = OPSEL_F10_HDX;
        tsel = 4'h9;
        media.set_traffic(3'h7);
        step(4);
        rst = 1'b1;
        step(1);
        check_defaults();
        tsel = TEST_NORMAL;
        step(1);
        rst = 1'b0;
        // Synchronisers still carry reset values for two edges after release
        step(2);
        check_defaults();
        step(1);
        check("config after reset", {1'b0, cfg}, 8'h00);
        check("lamps after reset", {2'h0, ind_n}, 8'h08);
    endtask

    initial begin
        step(6);
        check_defaults();
        rst = 1'b0;
        test_straps();
        test_flag();
        test_status();
        test_flash();
        test_mid_reset();
        results();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        results();
    end
endmodule
